// *** tb/hbsc_host_model.sv ***
// Purpose: host bus side with board glue
// Assumes: strobes held until acknowledge
// Notes: ack floats when not selected
`timescale 1ns/1ns
module hbsc_host_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [1:0] host_we_n,
    input wire logic host_oe_n,
    input wire logic wait_n,
    input wire logic [0:31] host_addr,
    input wire logic [0:15] host_data,
    output logic [15:0] dev_addr,
    output logic [15:0] dev_data,
    output logic chip_select_n,
    output logic low_byte_write_n,
    output logic high_byte_write_n,
    output logic low_byte_read_n,
    output logic high_byte_read_n,
    output tri transfer_ack
);
    logic seen_q = 1'h0;
    // host bit 0 is most significant: ascending slices keep their order, host bit 16 lands on dev bit 15
    assign dev_addr = host_addr[16:31];
    assign dev_data = host_data[0:15];
    // gated inverter, wait seen active high
    assign transfer_ack = chip_select_n ? 1'bz : ~wait_n;
    // host lane 0 strobe lands on the high byte
    assign high_byte_write_n = chip_select_n | host_we_n[0];
    assign low_byte_write_n = chip_select_n | host_we_n[1];
    assign high_byte_read_n = chip_select_n | host_oe_n;
    assign low_byte_read_n = chip_select_n | host_oe_n;
    initial chip_select_n = 1'h1;
    // select on go, release once acknowledged
    always @(posedge ref_clk) begin
        if (go) begin
            chip_select_n <= 1'h0;
        end else if (transfer_ack === 1'h1) begin
            seen_q <= 1'h1;
        end else if (seen_q && transfer_ack === 1'h0) begin
            chip_select_n <= 1'h1;
            seen_q <= 1'h0;
        end
    end
endmodule : hbsc_host_model

// *** tb/hbsc_props.sv ***
// Purpose: port checks for hbsc_host_port
// Assumes: straps stable across capture
// Notes: bound into every instance
`timescale 1ns/1ns
module hbsc_props (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic refresh_busy,
    input wire logic panel_power_on,
    input wire logic wait_n,
    input wire logic panel_power_out,
    input wire logic access_strobe,
    input hbsc_pkg::hbsc_mode_t bus_mode,
    input wire logic big_endian,
    input wire logic mode_reserved
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // a captured, usable configuration
    wire logic set_w = bus_mode != hbsc_pkg::HBSC_MODE_RESERVED;
    AST_HELD: assert property (set_w && $past(set_w) |-> $stable(bus_mode) && $stable(big_endian))
        else $error("configuration moved after capture");
    AST_ONEHOT: assert property ($onehot(bus_mode))
        else $error("bus mode not one-hot");
    AST_RSVD: assert property (mode_reserved |-> !set_w && wait_n && !access_strobe)
        else $error("reserved mode served an access");
    AST_PWR: assert property (set_w && $changed(panel_power_on) |=> $changed(panel_power_out))
        else $error("panel power did not follow request");
    AST_WAIT_ON: assert property (access_strobe |-> !wait_n ##1 !wait_n)
        else $error("wait not held at access");
    AST_WAIT_OFF: assert property (access_strobe && !refresh_busy ##1 !refresh_busy |=> wait_n)
        else $error("wait not released");
    AST_STRETCH: assert property (!wait_n && refresh_busy |=> !wait_n)
        else $error("wait released during refresh");
endmodule : hbsc_props
bind hbsc_host_port hbsc_props i_hbsc_props (.ref_clk, .rstn, .refresh_busy, .panel_power_on, .wait_n,
    .panel_power_out, .access_strobe, .bus_mode, .big_endian, .mode_reserved);

// *** tb/tb.sv ***
// Purpose: bench for hbsc_host_port
// Assumes: host model drives the strobes
// Notes: one reset per strap case
`timescale 1ns/1ns
module tb;
    logic ref_clk = 1'h0, rstn = 1'h0, bus_status_n = 1'h0, refresh_busy = 1'h0, panel_power_on = 1'h0;
    logic go = 1'h0, host_oe_n = 1'h1, chip_select_n, low_byte_write_n, high_byte_write_n, low_byte_read_n;
    logic high_byte_read_n, wait_n, panel_power_out, access_write, access_strobe, big_endian, mode_reserved;
    logic [4:0] config_strap = 5'h1F;
    logic [1:0] host_we_n = 2'h3, access_bytes;
    tri transfer_ack;
    logic [0:31] host_addr = 32'h0000_8002;
    logic [0:15] host_data = 16'hC001;
    logic [15:0] dev_addr, dev_data;
    hbsc_pkg::hbsc_mode_t bus_mode;
    int errors = 0, comparisons = 0, cycles = 0, lows = 0;
    hbsc_host_port i_hbsc_host_port (.ref_clk, .rstn, .config_strap, .bus_status_n, .chip_select_n,
        .low_byte_write_n, .high_byte_write_n, .low_byte_read_n, .high_byte_read_n, .refresh_busy,
        .panel_power_on, .wait_n, .panel_power_out, .access_write, .access_bytes, .access_strobe,
        .bus_mode, .big_endian, .mode_reserved);
    hbsc_host_model i_hbsc_host_model (.ref_clk, .go, .host_we_n, .host_oe_n, .wait_n, .host_addr, .host_data,
        .dev_addr, .dev_data, .chip_select_n,
        .low_byte_write_n, .high_byte_write_n, .low_byte_read_n, .high_byte_read_n, .transfer_ack);
    initial forever #50 ref_clk = ~ref_clk;
    // cycle ceiling and wait-low tally
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        lows <= lows + !wait_n;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic boot(input logic [4:0] s, input logic b);
        @(posedge ref_clk);
        rstn <= 1'h0;
        config_strap <= s;
        bus_status_n <= b;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'h1;
        repeat (8) @(posedge ref_clk);
    endtask : boot
    // every strap and bus-status code, then later strap changes
    task automatic scan_straps();
        logic [6:0] m;
        for (int i = 0; i < 64; i++) begin
            boot(i[5:1], i[0]);
            case (i[3:1])
                3'h0: m = 7'h01;
                3'h1: m = 7'h02;
                3'h3: m = 7'h04;
                3'h5: m = 7'h08;
                3'h7: m = i[0] ? 7'h20 : 7'h10;
                default: m = 7'h40;
            endcase
            check("bus_mode", m, bus_mode);
            check("mode_reserved", m == 7'h40, mode_reserved);
            check("big_endian", i[4], big_endian);
            config_strap <= ~config_strap;
            bus_status_n <= ~bus_status_n;
            repeat (4) @(posedge ref_clk);
            check("bus_mode_held", m, bus_mode);
            for (int p = 0; p < 2; p++) begin
                panel_power_on <= p[0];
                repeat (2) @(posedge ref_clk);
                check("panel_power_out", p[0] == i[5], panel_power_out);
            end
        end
    endtask : scan_straps
    // one host cycle, judged on lanes, direction and wait length
    task automatic access(input logic [1:0] we, input logic oe, input logic [1:0] eb, input logic ew,
        input int refresh, input int el);
        int start;
        start = lows;
        host_we_n <= we;
        host_oe_n <= oe;
        refresh_busy <= refresh > 0;
        go <= 1'h1;
        @(posedge ref_clk);
        go <= 1'h0;
        for (int k = 0; k < 60 && !(k > 2 && chip_select_n); k++) begin
            @(posedge ref_clk);
            if (k == refresh) refresh_busy <= 1'h0;
        end
        check("access_bytes", eb, access_bytes);
        check("access_write", ew, access_write);
        check("wait_low", 1'h1, refresh ? lows - start > el : lows - start == el);
        host_we_n <= 2'h3;
        host_oe_n <= 1'h1;
        @(posedge ref_clk);
    endtask : access
    task automatic complete_run();
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'h1;
        scan_straps();
        boot(5'h1F, 1'h0);
        check("dev_addr", 16'h8002, dev_addr);
        check("dev_data", 16'hC001, dev_data);
        access(2'h2, 1'h1, 2'h2, 1'h1, 0, 2);
        access(2'h1, 1'h1, 2'h1, 1'h1, 0, 2);
        access(2'h3, 1'h0, 2'h3, 1'h0, 0, 2);
        access(2'h0, 1'h1, 2'h3, 1'h1, 6, 2);
        boot(5'h1A, 1'h0);
        access(2'h0, 1'h1, 2'h0, 1'h0, 0, 0);
        complete_run();
    end
endmodule : tb

// *** verilog/hbsc_consts.svh ***
// Purpose: constants for the host bus strap configuration block
// Assumes: 16-bit host data path, straps sampled once per reset
// Notes: definitions only
`ifndef HBSC_CONSTS_SVH
`define HBSC_CONSTS_SVH

// strap bit positions inside config_strap
`define HBSC_STRAP_BUS_LSB 0
`define HBSC_STRAP_BUS_MSB 2
`define HBSC_STRAP_ENDIAN 3
`define HBSC_STRAP_PWRPOL 4

// reset values of the held configuration
`define HBSC_RST_BUS_SEL 3'h0
`define HBSC_RST_BUS_STATUS 1'h0
`define HBSC_RST_BIG_ENDIAN 1'h0
`define HBSC_RST_PWR_HIGH 1'h0

// host bus strap encodings
`define HBSC_SEL_PROC_A 3'h0
`define HBSC_SEL_PROC_B 3'h1
`define HBSC_SEL_STROBE_A 3'h3
`define HBSC_SEL_STROBE_B 3'h5
`define HBSC_SEL_GENERIC 3'h7

// cycles from an accepted access to data ready or write taken
`define HBSC_ACCESS_CYCLES 2'h2

`endif

// *** verilog/hbsc_host_port.sv ***
// Purpose: strap capture, mode decode and wait generation of the host bus port
// Assumes: straps and host strobes are asynchronous pins, synchronised here
// Notes: display refresh contention appears as refresh_busy
`timescale 1ns/1ns
`include "hbsc_consts.svh"

module hbsc_host_port (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [4:0] config_strap,
    input wire logic bus_status_n,
    input wire logic chip_select_n,
    input wire logic low_byte_write_n,
    input wire logic high_byte_write_n,
    input wire logic low_byte_read_n,
    input wire logic high_byte_read_n,
    input wire logic refresh_busy,
    input wire logic panel_power_on,
    output logic wait_n,
    output logic panel_power_out,
    output logic access_write,
    output logic [1:0] access_bytes,
    output logic access_strobe,
    output hbsc_pkg::hbsc_mode_t bus_mode,
    output logic big_endian,
    output logic mode_reserved
);

    // reset release through two flops
    // the raw reset pin is asynchronous to ref_clk
    // its assertion reaches every flop at once
    // its release is retimed so that no flop leaves reset
    // one cycle ahead of its neighbours
    // every other process of this block uses rst_sync_q only
    // the first flop may go metastable on release
    // only the second flop is read by the rest of the logic
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'h0;
            rst_sync_q <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // two-flop synchronisers for the pins
    // straps, bus status, chip select and the byte strobes
    // all come from the board and carry no timing relation
    // to ref_clk, so each passes two flops before use
    // the idle level of every one of these pins is high,
    // so the flops reset to ones: no false access and
    // no false strobe appears while reset is released
    // the cost is two cycles of latency on every pin
    // the host holds its strobes until acknowledge,
    // so the latency only lengthens the access
    localparam int PINS = 11;
    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] pin_meta_q;
    logic [PINS-1:0] pin_sync_q;
    assign pin_raw = {config_strap, bus_status_n, chip_select_n, low_byte_write_n, high_byte_write_n,
        low_byte_read_n, high_byte_read_n};
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    wire [4:0] strap_s = pin_sync_q[10:6];
    wire bus_status_s = pin_sync_q[5];
    wire cs_n_s = pin_sync_q[4];
    wire wr_lo_n_s = pin_sync_q[3];
    wire wr_hi_n_s = pin_sync_q[2];
    wire rd_lo_n_s = pin_sync_q[1];
    wire rd_hi_n_s = pin_sync_q[0];

    // one capture after release: the synchronisers need two edges to settle
    // the straps must stand still from before the release
    // until the capture edge; a board that moves them
    // later has no effect on the held configuration
    // the held copy stands until the next reset
    // captured_q blocks host accesses until then:
    // before capture the mode is unknown, so wait stays high
    // settle_q stops at 2 and never wraps
    logic [1:0] settle_q;
    logic captured_q;
    hbsc_pkg::hbsc_cfg_t cfg_q;
    wire capture_now = (settle_q == 2'h2) && !captured_q;
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            settle_q <= 2'h0;
            captured_q <= 1'h0;
            cfg_q <= {`HBSC_RST_BUS_SEL, `HBSC_RST_BUS_STATUS, `HBSC_RST_BIG_ENDIAN, `HBSC_RST_PWR_HIGH};
        end else begin
            if (settle_q != 2'h2) settle_q <= settle_q + 2'h1;
            if (capture_now) begin
                captured_q <= 1'h1;
                cfg_q <= {strap_s[`HBSC_STRAP_BUS_MSB:`HBSC_STRAP_BUS_LSB], bus_status_s,
                    strap_s[`HBSC_STRAP_ENDIAN], strap_s[`HBSC_STRAP_PWRPOL]};
            end
        end
    end

    // decode of the held host bus strap
    // three strap bits plus bus status give seven outcomes
    // the generic code is the only one that reads bus status
    // codes 2, 4 and 6 have no protocol behind them
    // and fall to the reserved outcome in the default arm
    // a reserved outcome refuses every access
    function automatic hbsc_pkg::hbsc_mode_t hbsc_decode(input logic [2:0] sel, input logic bs);
        unique case (sel)
            `HBSC_SEL_PROC_A: hbsc_decode = hbsc_pkg::HBSC_MODE_PROC_A;
            `HBSC_SEL_PROC_B: hbsc_decode = hbsc_pkg::HBSC_MODE_PROC_B;
            `HBSC_SEL_STROBE_A: hbsc_decode = hbsc_pkg::HBSC_MODE_STROBE_A;
            `HBSC_SEL_STROBE_B: hbsc_decode = hbsc_pkg::HBSC_MODE_STROBE_B;
            `HBSC_SEL_GENERIC: hbsc_decode = bs ? hbsc_pkg::HBSC_MODE_GENERIC_2 : hbsc_pkg::HBSC_MODE_GENERIC_1;
            default: hbsc_decode = hbsc_pkg::HBSC_MODE_RESERVED;
        endcase
    endfunction : hbsc_decode

    wire hbsc_pkg::hbsc_mode_t mode_d = hbsc_decode(cfg_q.bus_sel, cfg_q.bus_status);
    wire mode_ok = captured_q && (mode_d != hbsc_pkg::HBSC_MODE_RESERVED);

    // access detect: chip select with any byte strobe (generic one strobes)
    wire any_wr = !wr_lo_n_s || !wr_hi_n_s;
    wire any_rd = !rd_lo_n_s || !rd_hi_n_s;
    wire req = mode_ok && !cs_n_s && (any_wr || any_rd);

    // access sequencer: wait low until data ready or write taken
    // idle: waits for chip select with a byte strobe
    // busy: counts cycles in which refresh leaves the resource free
    // a refresh cycle stretches wait without losing the count
    // done: wait is high again; the host ends its cycle
    // and the sequencer waits for chip select to go away,
    // so one held strobe never starts a second access
    // the host sees wait inverted as its acknowledge
    hbsc_pkg::hbsc_state_t state_q;
    logic [1:0] cnt_q;
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= hbsc_pkg::HBSC_ST_IDLE;
            cnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                hbsc_pkg::HBSC_ST_IDLE: if (req) begin
                    state_q <= hbsc_pkg::HBSC_ST_BUSY;
                    cnt_q <= 2'h0;
                end
                hbsc_pkg::HBSC_ST_BUSY: if (!refresh_busy) begin
                    if (cnt_q == `HBSC_ACCESS_CYCLES - 2'h1) state_q <= hbsc_pkg::HBSC_ST_DONE;
                    else cnt_q <= cnt_q + 2'h1;
                end
                hbsc_pkg::HBSC_ST_DONE: if (cs_n_s) state_q <= hbsc_pkg::HBSC_ST_IDLE;
            endcase
        end
    end

    // registered outputs
    // every output is a flop, so the board sees no glitch
    // wait drops on the take edge and rises on the edge
    // that ends the access count
    // access_strobe marks the take for one cycle
    // access_write and access_bytes hold until the next take
    // bus_mode reads reserved until the straps are captured
    // panel power is low in reset, follows the request active low until capture, then in the strap polarity
    always_ff @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wait_n <= 1'h1;
            panel_power_out <= 1'h0;
            access_write <= 1'h0;
            access_bytes <= 2'h0;
            access_strobe <= 1'h0;
            bus_mode <= hbsc_pkg::HBSC_MODE_RESERVED;
            big_endian <= 1'h0;
            mode_reserved <= 1'h0;
        end else begin
            wait_n <= !((state_q == hbsc_pkg::HBSC_ST_IDLE && req) || state_q == hbsc_pkg::HBSC_ST_BUSY)
                || (state_q == hbsc_pkg::HBSC_ST_BUSY && !refresh_busy && cnt_q == `HBSC_ACCESS_CYCLES - 2'h1);
            panel_power_out <= cfg_q.pwr_active_high ? panel_power_on : !panel_power_on;
            access_strobe <= state_q == hbsc_pkg::HBSC_ST_IDLE && req;
            if (state_q == hbsc_pkg::HBSC_ST_IDLE && req) begin
                access_write <= any_wr;
                access_bytes <= any_wr ? {!wr_hi_n_s, !wr_lo_n_s} : {!rd_hi_n_s, !rd_lo_n_s};
            end
            bus_mode <= captured_q ? mode_d : hbsc_pkg::HBSC_MODE_RESERVED;
            big_endian <= cfg_q.big_endian;
            mode_reserved <= captured_q && (mode_d == hbsc_pkg::HBSC_MODE_RESERVED);
        end
    end

endmodule : hbsc_host_port

// *** verilog/hbsc_pkg.sv ***
// Purpose: types for the host bus strap configuration block
// Assumes: nothing beyond the constants header
// Notes: no imports anywhere; use hbsc_pkg::name
package hbsc_pkg;

    // decoded host bus protocol
    typedef enum logic [6:0] {
        HBSC_MODE_PROC_A = 7'h01,
        HBSC_MODE_PROC_B = 7'h02,
        HBSC_MODE_STROBE_A = 7'h04,
        HBSC_MODE_STROBE_B = 7'h08,
        HBSC_MODE_GENERIC_1 = 7'h10,
        HBSC_MODE_GENERIC_2 = 7'h20,
        HBSC_MODE_RESERVED = 7'h40
    } hbsc_mode_t;

    // configuration held from reset release
    typedef struct packed {
        logic [2:0] bus_sel;
        logic bus_status;
        logic big_endian;
        logic pwr_active_high;
    } hbsc_cfg_t;

    // access sequencer states
    typedef enum logic [2:0] {
        HBSC_ST_IDLE = 3'h1,
        HBSC_ST_BUSY = 3'h2,
        HBSC_ST_DONE = 3'h4
    } hbsc_state_t;

endpackage : hbsc_pkg
